// *** pdc_pkg.sv ***
package pdc_pkg;

  // Register byte offsets within one channel.
  localparam logic [7:0] OFF_MEM_ADDR  = 8'h00;
  localparam logic [7:0] OFF_REMAIN    = 8'h08;
  localparam logic [7:0] OFF_ADDR_RLD  = 8'h0c;
  localparam logic [7:0] OFF_CNT_RLD   = 8'h10;
  localparam logic [7:0] OFF_COMMAND   = 8'h14;
  localparam logic [7:0] OFF_MODE      = 8'h18;
  localparam logic [7:0] OFF_STATE     = 8'h1c;
  localparam logic [7:0] OFF_MASK_SET  = 8'h20;
  localparam logic [7:0] OFF_MASK_CLR  = 8'h24;
  localparam logic [7:0] OFF_MASK_VIEW = 8'h28;
  localparam logic [7:0] OFF_FLAG_VIEW = 8'h2c;

  // Field positions.
  localparam int CMD_ENABLE_BIT  = 0;
  localparam int CMD_DISABLE_BIT = 1;
  localparam int CMD_ERRCLR_BIT  = 8;
  localparam int MODE_EVENT_BIT  = 2;
  localparam int MODE_RING_BIT   = 3;
  localparam int FLAG_RCZ_BIT    = 0;
  localparam int FLAG_TRC_BIT    = 1;
  localparam int FLAG_ERR_BIT    = 2;

  // Transfer width encodings.
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // Reset values.
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [2:0]  RST_MASK  = 3'h0;
  localparam logic [3:0]  RST_MODE  = 4'h0;

  // Channel transfer state.
  typedef enum logic [1:0] {
    PDC_IDLE = 2'b00,
    PDC_ARM  = 2'b01,
    PDC_BUSY = 2'b10
  } pdc_state_t;

  // Memory-side item request carried to the bus engine.
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [1:0]  size;
  } pdc_item_req_t;

endpackage : pdc_pkg

// *** pdc_channel.sv ***
// Summary of operation
// - The 16-bit remaining count holds items left, decremented per item, loaded by software.
// - On count reaching zero with nonzero reload, copy address reload into current address.
// - On count reaching zero with positive reload count, reload the count and continue.
// - Count zero with reload count zero stops all further transfers.
// - A reload without ring mode clears the reload count register.
// - Ring mode (mode bit 3) keeps both reload registers after reload.
// - Mode bit 2 selects start on peripheral request or after a peripheral event.
// - Width field: 0 byte, 1 halfword, 2 word, 3 reserved.
// - Writing one to command bit 8 clears the error flag, resuming transfers.
// - Writing one to command bit 1 disables transfers; zero does nothing.
// - Writing one to command bit 0 enables transfers unless bit 1 is also one; zero does nothing.
// - Status bit 0 shows enabled, set by enable and cleared by disable.
// - Writing ones to mask-set sets mask bits error, complete, reload-zero.
// - Writing ones to mask-clear clears mask bits; zeros leave them.
// - Mask bit one means source enabled; mask is read-only, resets zero.
// - Error flag sets on any transfer error and holds until error clear.
// - Complete flag is one exactly when count and reload count are zero.
// - Reload-zero flag is one exactly when reload count is zero.
// - Current address always points at the next location to access.
`timescale 1ns/1ps
`default_nettype none
module pdc_channel (
  input  wire logic          clk_in,          // System clock, 25 MHz.
  input  wire logic          resetn_in,       // Asynchronous reset, active low.
  input  wire logic [7:0]    avs_address_in,  // Byte address within the channel.
  input  wire logic          avs_read_in,     // Avalon read strobe.
  input  wire logic          avs_write_in,    // Avalon write strobe.
  input  wire logic [31:0]   avs_writedata_in,// Avalon write data.
  input  wire logic [3:0]    avs_byteenable_in,// Avalon byte enables.
  output logic [31:0]        avs_readdata_out,// Avalon read data.
  output logic               avs_waitrequest_out, // Avalon wait request.
  input  wire logic          periph_req_in,   // Peripheral handshake request.
  input  wire logic          periph_event_in, // Peripheral event pulse.
  output pdc_pkg::pdc_item_req_t item_req_out,// Item request to memory engine.
  input  wire logic          item_done_in,    // Item completed by engine.
  input  wire logic          item_error_in,   // Item ended with a bus error.
  output logic               irq_out          // Channel interrupt request.
);

  // Register state.
  logic [31:0] cur_addr_reg, cur_addr_next;
  logic [15:0] remain_reg, remain_next;
  logic [31:0] addr_rld_reg, addr_rld_next;
  logic [15:0] cnt_rld_reg, cnt_rld_next;
  logic [3:0]  mode_reg, mode_next;
  logic        enabled_reg, enabled_next;
  logic        error_reg, error_next;
  logic [2:0]  mask_reg, mask_next;
  logic        ack_reg, ack_next;
  logic        event_seen_reg, event_seen_next;
  pdc_pkg::pdc_state_t state_reg, state_next;
  logic [31:0] rdata_reg, rdata_next;

  logic        wr_hit;
  logic        rd_hit;
  logic [2:0]  flags;
  logic        start_ok;
  logic        be0_en_only;

  // Command write that enables without disabling in the same word.
  assign be0_en_only = avs_byteenable_in[0] && avs_writedata_in[0] && !avs_writedata_in[1];

  // Byte count of one item; reserved width falls back to a word.
  function automatic logic [31:0] item_bytes(input logic [1:0] size);
    case (size)
      pdc_pkg::SIZE_BYTE: item_bytes = 32'h0000_0001;
      pdc_pkg::SIZE_HALF: item_bytes = 32'h0000_0002;
      default:            item_bytes = 32'h0000_0004;
    endcase
  endfunction

  // Merge write data into a register word under the byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // One wait cycle per access keeps read data registered.
  assign wr_hit = avs_write_in && !ack_reg;
  assign rd_hit = avs_read_in && !ack_reg;
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_reg;
  assign avs_readdata_out = rdata_reg;

  // Live status flags.
  always_comb begin
    flags = 3'h0;
    flags[pdc_pkg::FLAG_ERR_BIT] = error_reg;
    flags[pdc_pkg::FLAG_TRC_BIT] = (remain_reg == 16'h0000) && (cnt_rld_reg == 16'h0000);
    flags[pdc_pkg::FLAG_RCZ_BIT] = (cnt_rld_reg == 16'h0000);
  end

  assign irq_out = |(flags & mask_reg);

  // Start condition depends on the trigger mode.
  assign start_ok = mode_reg[pdc_pkg::MODE_EVENT_BIT] ? event_seen_reg : periph_req_in;

  assign item_req_out.valid = (state_reg == pdc_pkg::PDC_BUSY);
  assign item_req_out.addr  = cur_addr_reg;
  assign item_req_out.size  = mode_reg[1:0];

  // Next-state logic for registers, commands and the transfer engine.
  always_comb begin
    logic [31:0] wd;
    logic [3:0]  be;
    logic [31:0] mw;
    wd = avs_writedata_in;
    mw = pdc_pkg::RST_WORD;
    be = avs_byteenable_in;
    cur_addr_next   = cur_addr_reg;
    remain_next     = remain_reg;
    addr_rld_next   = addr_rld_reg;
    cnt_rld_next    = cnt_rld_reg;
    mode_next       = mode_reg;
    enabled_next    = enabled_reg;
    error_next      = error_reg;
    mask_next       = mask_reg;
    state_next      = state_reg;
    event_seen_next = event_seen_reg || periph_event_in;
    ack_next        = (avs_read_in || avs_write_in) && !ack_reg;
    rdata_next      = rdata_reg;

    if (wr_hit) begin
      case (avs_address_in)
        pdc_pkg::OFF_MEM_ADDR: cur_addr_next = merge(cur_addr_reg, wd, be);
        pdc_pkg::OFF_REMAIN: begin
          mw          = merge({16'h0000, remain_reg}, wd, be);
          remain_next = mw[15:0];
        end
        pdc_pkg::OFF_ADDR_RLD: addr_rld_next = merge(addr_rld_reg, wd, be);
        pdc_pkg::OFF_CNT_RLD: begin
          mw           = merge({16'h0000, cnt_rld_reg}, wd, be);
          cnt_rld_next = mw[15:0];
        end
        pdc_pkg::OFF_MODE: begin
          mw        = merge({28'h0000_000, mode_reg}, wd, be);
          mode_next = mw[3:0];
        end
        pdc_pkg::OFF_COMMAND: begin
          if (be[0] && wd[pdc_pkg::CMD_ENABLE_BIT]) begin
            enabled_next = 1'b1;
          end
          if (be[0] && wd[pdc_pkg::CMD_DISABLE_BIT]) begin
            enabled_next = 1'b0;
          end
          if (be[1] && wd[pdc_pkg::CMD_ERRCLR_BIT]) begin
            error_next = 1'b0;
          end
        end
        pdc_pkg::OFF_MASK_SET: if (be[0]) mask_next = mask_reg | wd[2:0];
        pdc_pkg::OFF_MASK_CLR: if (be[0]) mask_next = mask_reg & ~wd[2:0];
        default: ;
      endcase
    end

    if (rd_hit) begin
      case (avs_address_in)
        pdc_pkg::OFF_MEM_ADDR:  rdata_next = cur_addr_reg;
        pdc_pkg::OFF_REMAIN:    rdata_next = {16'h0000, remain_reg};
        pdc_pkg::OFF_ADDR_RLD:  rdata_next = addr_rld_reg;
        pdc_pkg::OFF_CNT_RLD:   rdata_next = {16'h0000, cnt_rld_reg};
        pdc_pkg::OFF_MODE:      rdata_next = {28'h0000_000, mode_reg};
        pdc_pkg::OFF_STATE:     rdata_next = {31'h0000_0000, enabled_reg};
        pdc_pkg::OFF_MASK_VIEW: rdata_next = {29'h0000_0000, mask_reg};
        pdc_pkg::OFF_FLAG_VIEW: rdata_next = {29'h0000_0000, flags};
        default:                rdata_next = pdc_pkg::RST_WORD;
      endcase
    end

    // Transfer engine; a hardware error wins over a same-cycle clear.
    case (state_reg)
      pdc_pkg::PDC_IDLE: begin
        if (enabled_reg && !error_reg && remain_reg != 16'h0000) begin
          state_next = pdc_pkg::PDC_ARM;
        end
      end
      pdc_pkg::PDC_ARM: begin
        if (!enabled_reg || error_reg || remain_reg == 16'h0000) begin
          state_next = pdc_pkg::PDC_IDLE;
        end else if (start_ok) begin
          state_next = pdc_pkg::PDC_BUSY;
          event_seen_next = periph_event_in;
        end
      end
      pdc_pkg::PDC_BUSY: begin
        if (item_error_in) begin
          error_next = 1'b1;
          state_next = pdc_pkg::PDC_IDLE;
        end else if (item_done_in) begin
          cur_addr_next = cur_addr_reg + item_bytes(mode_reg[1:0]);
          remain_next = remain_reg - 16'h0001;
          if (remain_reg == 16'h0001 && cnt_rld_reg != 16'h0000) begin
            cur_addr_next = addr_rld_reg;
            remain_next = cnt_rld_reg;
            if (!mode_reg[pdc_pkg::MODE_RING_BIT]) begin
              cnt_rld_next = 16'h0000;
              addr_rld_next = pdc_pkg::RST_WORD;
            end
          end
          state_next = pdc_pkg::PDC_IDLE;
        end
      end
      default: state_next = pdc_pkg::PDC_IDLE;
    endcase
  end

  // Register all state.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cur_addr_reg   <= pdc_pkg::RST_WORD;
      remain_reg     <= pdc_pkg::RST_COUNT;
      addr_rld_reg   <= pdc_pkg::RST_WORD;
      cnt_rld_reg    <= pdc_pkg::RST_COUNT;
      mode_reg       <= pdc_pkg::RST_MODE;
      enabled_reg    <= 1'b0;
      error_reg      <= 1'b0;
      mask_reg       <= pdc_pkg::RST_MASK;
      ack_reg        <= 1'b0;
      event_seen_reg <= 1'b0;
      state_reg      <= pdc_pkg::PDC_IDLE;
      rdata_reg      <= pdc_pkg::RST_WORD;
    end else begin
      cur_addr_reg   <= cur_addr_next;
      remain_reg     <= remain_next;
      addr_rld_reg   <= addr_rld_next;
      cnt_rld_reg    <= cnt_rld_next;
      mode_reg       <= mode_next;
      enabled_reg    <= enabled_next;
      error_reg      <= error_next;
      mask_reg       <= mask_next;
      ack_reg        <= ack_next;
      event_seen_reg <= event_seen_next;
      state_reg      <= state_next;
      rdata_reg      <= rdata_next;
    end
  end

  // Checks.
  AST_IRQ: assert property (@(posedge clk_in) disable iff (!resetn_in)
    irq_out == ((error_reg && mask_reg[2])
                || (remain_reg == 16'h0 && cnt_rld_reg == 16'h0 && mask_reg[1])
                || (cnt_rld_reg == 16'h0 && mask_reg[0]))) else $error("Interrupt mismatch.");
  AST_TRC: assert property (@(posedge clk_in) disable iff (!resetn_in)
    flags[1] == (remain_reg == 16'h0 && cnt_rld_reg == 16'h0)) else $error("Complete flag bad.");
  AST_STOP: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (remain_reg == 16'h0) |-> ##1 state_reg != pdc_pkg::PDC_BUSY) else $error("Moved at zero.");
  AST_DEC: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_reg == pdc_pkg::PDC_BUSY && item_done_in && !item_error_in && remain_reg > 16'h1)
    |=> remain_reg == $past(remain_reg) - 16'h1) else $error("Count not decremented.");
  AST_RELOAD: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_reg == pdc_pkg::PDC_BUSY && item_done_in && !item_error_in
     && remain_reg == 16'h1 && cnt_rld_reg != 16'h0)
    |=> remain_reg == $past(cnt_rld_reg) && cur_addr_reg == $past(addr_rld_reg))
    else $error("Reload failed.");
  AST_RING: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_reg == pdc_pkg::PDC_BUSY && item_done_in && !item_error_in && remain_reg == 16'h1
     && cnt_rld_reg != 16'h0 && !mode_reg[3] && !wr_hit) |=> cnt_rld_reg == 16'h0)
    else $error("Reload count not cleared.");
  AST_ERR: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_reg == pdc_pkg::PDC_BUSY && item_error_in) |=> error_reg) else $error("Error lost.");
  AST_EN: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_hit && avs_address_in == pdc_pkg::OFF_COMMAND && be0_en_only) |=> enabled_reg)
    else $error("Enable ignored.");
  AST_MASK: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_hit && avs_address_in == pdc_pkg::OFF_MASK_SET && avs_byteenable_in[0])
    |=> (mask_reg & $past(avs_writedata_in[2:0])) == $past(avs_writedata_in[2:0]))
    else $error("Mask set failed.");

  COV_RELOAD: cover property (@(posedge clk_in) disable iff (!resetn_in)
    state_reg == pdc_pkg::PDC_BUSY && item_done_in && remain_reg == 16'h1 && cnt_rld_reg != 0);
  COV_ERR: cover property (@(posedge clk_in) disable iff (!resetn_in) error_reg && irq_out);
  COV_EVT: cover property (@(posedge clk_in) disable iff (!resetn_in)
    mode_reg[2] && state_reg == pdc_pkg::PDC_BUSY);

endmodule // pdc_channel
`default_nettype wire

// *** pdc_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pdc_far_model (
  input  wire logic                   clk_in,    // System clock.
  input  wire logic                   resetn_in, // Reset, active low.
  input  wire pdc_pkg::pdc_item_req_t item_in,   // Item request from the channel.
  input  wire logic [3:0]             delay_in,  // Wait cycles before each answer.
  input  wire logic                   fail_in,   // Answer with a bus error.
  output logic                        done_out,  // Item completed pulse.
  output logic                        error_out, // Item bus error pulse.
  output logic [15:0]                 items_out, // Items answered so far.
  output logic [31:0]                 addr_out   // Address of the last item.
);
  logic [3:0] wait_reg;
  logic       fired_reg;

  // One answer per request; fired_reg stops a second answer while valid lingers.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_out  <= 1'b0;
      error_out <= 1'b0;
      fired_reg <= 1'b0;
      wait_reg  <= 4'h0;
      items_out <= 16'h0000;
      addr_out  <= 32'h0000_0000;
    end else begin
      done_out  <= 1'b0;
      error_out <= 1'b0;
      if (!item_in.valid) begin
        fired_reg <= 1'b0;
        wait_reg  <= 4'h0;
      end else if (!fired_reg && wait_reg >= delay_in) begin
        done_out  <= !fail_in;
        error_out <= fail_in;
        fired_reg <= 1'b1;
        items_out <= items_out + 16'h0001;
        addr_out  <= item_in.addr;
      end else if (!fired_reg) begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule // pdc_far_model
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("ERROR %0t: got %h want %h", $time, (a), (b)); end end
module tb;
  logic                   clk_in = 1'b0;
  logic                   resetn_in = 1'b0;
  logic [7:0]             adr = 8'h00;
  logic                   rd = 1'b0, wr = 1'b0, preq = 1'b0, pevt = 1'b0, fail = 1'b0;
  logic [31:0]            wdat = 32'h0000_0000;
  logic [3:0]             dly = 4'h0;
  logic [31:0]            rdat, q, last_addr;
  logic                   wreq, done, err, irq;
  pdc_pkg::pdc_item_req_t item;
  logic [15:0]            items, n0, st, step;
  int                     errors = 0, check_count = 0, i;
  logic [7:0]             offs [7] = '{pdc_pkg::OFF_MEM_ADDR, pdc_pkg::OFF_REMAIN,
    pdc_pkg::OFF_ADDR_RLD, pdc_pkg::OFF_CNT_RLD, pdc_pkg::OFF_MODE, pdc_pkg::OFF_STATE,
    pdc_pkg::OFF_MASK_VIEW};

  // Free-running 25 MHz clock.
  always #20 clk_in = ~clk_in;

  pdc_channel uut (.clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .periph_req_in(preq),
    .periph_event_in(pevt), .item_req_out(item), .item_done_in(done),
    .item_error_in(err), .irq_out(irq));

  pdc_far_model far (.clk_in(clk_in), .resetn_in(resetn_in), .item_in(item), .delay_in(dly),
    .fail_in(fail), .done_out(done), .error_out(err), .items_out(items), .addr_out(last_addr));

  // Single exit point for the run.
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One bus cycle; waitrequest is sampled at each rising edge, data taken where it is low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int k;
    k = 0;
    @(posedge clk_in);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk_in);
      k++;
    end while (wreq !== 1'b0 && k < 20);
    if (k >= 20) begin
      errors++;
      report_and_stop();
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    `CHK(q, {16'h0000, e})
  endtask

  // Polls a register until the masked value appears, with a bound.
  task automatic waitfor(input logic [7:0] a, input logic [15:0] m, input logic [15:0] v);
    int k;
    for (k = 0; k < 400; k++) begin
      bus(1'b0, a, 16'h0000);
      if ((q[15:0] & m) === v) break;
    end
    if (k >= 400) begin
      errors++;
      report_and_stop();
    end
  endtask

  task automatic idle20();
    n0 = items;
    repeat (20) @(posedge clk_in);
  endtask

  // Hang guard well inside the cycle budget.
  initial begin
    repeat (90000) @(posedge clk_in);
    errors++;
    report_and_stop();
  end

  // Main sequence of register-level tests.
  initial begin
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    for (i = 0; i < 7; i++) rchk(offs[i], 16'h0000);
    rchk(pdc_pkg::OFF_FLAG_VIEW, 16'h0003);
    rchk(8'h30, 16'h0000);
    wreg(pdc_pkg::OFF_STATE, 16'h0001);
    rchk(pdc_pkg::OFF_STATE, 16'h0000);
    $display("Test reset values finished");
    wreg(pdc_pkg::OFF_MASK_SET, 16'h0005);
    rchk(pdc_pkg::OFF_MASK_VIEW, 16'h0005);
    wreg(pdc_pkg::OFF_MASK_SET, 16'h0000);
    rchk(pdc_pkg::OFF_MASK_VIEW, 16'h0005);
    wreg(pdc_pkg::OFF_MASK_CLR, 16'h0001);
    rchk(pdc_pkg::OFF_MASK_VIEW, 16'h0004);
    wreg(pdc_pkg::OFF_MASK_CLR, 16'h0000);
    rchk(pdc_pkg::OFF_MASK_VIEW, 16'h0004);
    wreg(pdc_pkg::OFF_MASK_SET, 16'h0002);
    `CHK(irq, 1'b1)
    wreg(pdc_pkg::OFF_MASK_CLR, 16'h0002);
    `CHK(irq, 1'b0)
    wreg(pdc_pkg::OFF_COMMAND, 16'h0000);
    rchk(pdc_pkg::OFF_STATE, 16'h0000);
    wreg(pdc_pkg::OFF_COMMAND, 16'h0001);
    rchk(pdc_pkg::OFF_STATE, 16'h0001);
    wreg(pdc_pkg::OFF_COMMAND, 16'h0000);
    rchk(pdc_pkg::OFF_STATE, 16'h0001);
    wreg(pdc_pkg::OFF_COMMAND, 16'h0002);
    rchk(pdc_pkg::OFF_STATE, 16'h0000);
    $display("Test masks and enable finished");
    for (i = 0; i < 4; i++) begin
      st = 16'(i);
      step = (i == 0) ? 16'h0001 : (i == 1) ? 16'h0002 : 16'h0004;
      dly <= 4'(i * 3);
      wreg(pdc_pkg::OFF_MEM_ADDR, 16'h0100);
      wreg(pdc_pkg::OFF_MODE, st);
      rchk(pdc_pkg::OFF_MODE, st);
      wreg(pdc_pkg::OFF_REMAIN, 16'h0003);
      wreg(pdc_pkg::OFF_COMMAND, 16'h0001);
      idle20();
      `CHK(items, n0)
      preq <= 1'b1;
      waitfor(pdc_pkg::OFF_REMAIN, 16'hffff, 16'h0000);
      `CHK(16'(items - n0), 16'h0003)
      `CHK(last_addr[15:0], 16'h0100 + st - st + step + step)
      rchk(pdc_pkg::OFF_MEM_ADDR, 16'h0100 + step + step + step);
      idle20();
      `CHK(items, n0)
      preq <= 1'b0;
      wreg(pdc_pkg::OFF_COMMAND, 16'h0002);
    end
    $display("Test widths finished");
    preq <= 1'b1;
    dly <= 4'h1;
    wreg(pdc_pkg::OFF_MODE, 16'h0002);
    wreg(pdc_pkg::OFF_MEM_ADDR, 16'h0200);
    wreg(pdc_pkg::OFF_REMAIN, 16'h0002);
    wreg(pdc_pkg::OFF_ADDR_RLD, 16'h0400);
    wreg(pdc_pkg::OFF_CNT_RLD, 16'h0003);
    rchk(pdc_pkg::OFF_FLAG_VIEW, 16'h0000);
    n0 = items;
    wreg(pdc_pkg::OFF_COMMAND, 16'h0001);
    waitfor(pdc_pkg::OFF_FLAG_VIEW, 16'h0002, 16'h0002);
    `CHK(16'(items - n0), 16'h0005)
    rchk(pdc_pkg::OFF_MEM_ADDR, 16'h040c);
    rchk(pdc_pkg::OFF_CNT_RLD, 16'h0000);
    rchk(pdc_pkg::OFF_ADDR_RLD, 16'h0000);
    rchk(pdc_pkg::OFF_FLAG_VIEW, 16'h0003);
    wreg(pdc_pkg::OFF_COMMAND, 16'h0002);
    $display("Test reload finished");
    wreg(pdc_pkg::OFF_MODE, 16'h000a);
    wreg(pdc_pkg::OFF_MEM_ADDR, 16'h0300);
    wreg(pdc_pkg::OFF_REMAIN, 16'h0001);
    wreg(pdc_pkg::OFF_ADDR_RLD, 16'h0500);
    wreg(pdc_pkg::OFF_CNT_RLD, 16'h0002);
    n0 = items;
    wreg(pdc_pkg::OFF_COMMAND, 16'h0001);
    for (i = 0; i < 600 && 16'(items - n0) < 16'h0007; i++) @(posedge clk_in);
    wreg(pdc_pkg::OFF_COMMAND, 16'h0002);
    `CHK(16'(items - n0) >= 16'h0007, 1'b1)
    `CHK(last_addr[15:4], 12'h050)
    rchk(pdc_pkg::OFF_CNT_RLD, 16'h0002);
    rchk(pdc_pkg::OFF_ADDR_RLD, 16'h0500);
    $display("Test ring finished");
    wreg(pdc_pkg::OFF_MODE, 16'h0006);
    wreg(pdc_pkg::OFF_CNT_RLD, 16'h0000);
    wreg(pdc_pkg::OFF_MEM_ADDR, 16'h0600);
    wreg(pdc_pkg::OFF_REMAIN, 16'h0001);
    wreg(pdc_pkg::OFF_COMMAND, 16'h0001);
    idle20();
    `CHK(items, n0)
    pevt <= 1'b1;
    @(posedge clk_in);
    pevt <= 1'b0;
    waitfor(pdc_pkg::OFF_REMAIN, 16'hffff, 16'h0000);
    `CHK(items, n0 + 16'h0001)
    rchk(pdc_pkg::OFF_MEM_ADDR, 16'h0604);
    wreg(pdc_pkg::OFF_COMMAND, 16'h0002);
    $display("Test event start finished");
    fail <= 1'b1;
    wreg(pdc_pkg::OFF_MODE, 16'h0002);
    wreg(pdc_pkg::OFF_MEM_ADDR, 16'h0700);
    wreg(pdc_pkg::OFF_REMAIN, 16'h0002);
    wreg(pdc_pkg::OFF_COMMAND, 16'h0001);
    waitfor(pdc_pkg::OFF_FLAG_VIEW, 16'h0004, 16'h0004);
    fail <= 1'b0;
    `CHK(irq, 1'b1)
    idle20();
    `CHK(items, n0)
    wreg(pdc_pkg::OFF_COMMAND, 16'h0000);
    rchk(pdc_pkg::OFF_FLAG_VIEW, 16'h0005);
    wreg(pdc_pkg::OFF_MEM_ADDR, 16'h0700);
    wreg(pdc_pkg::OFF_COMMAND, 16'h0100);
    waitfor(pdc_pkg::OFF_REMAIN, 16'hffff, 16'h0000);
    rchk(pdc_pkg::OFF_FLAG_VIEW, 16'h0003);
    `CHK(irq, 1'b0)
    $display("Test error recovery finished");
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
